// file: rtl/spiop_port.sv
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
// Function
// - Mux picks peripheral or port for data/enable
// - Port output never loops into peripheral input
// - Active peripheral disables port driver, pin readable
// - Direction one is input, zero is output
// - Reset forces every pin to input
// - Latch reads stored value, writes update it
// - Pin value reads pins, writes hit latch
// - Unimplemented bits read zero everywhere
// - Open-drain bit drives low only, releases high
// - Analog-configured pins read as zero
// - Input-only shared pins are pure port pins
module spiop_port
   import spiop_pkg::*;
#(
   parameter int WIDTH = SPIOP_WIDTH,
   parameter logic [SPIOP_WIDTH-1:0] IMPL_MASK = SPIOP_IMPL_DEF,
   parameter logic [SPIOP_WIDTH-1:0] PERIPH_OUT_MASK = SPIOP_PERIPH_OUT_DEF
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [SPIOP_AW-1:0] addr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [WIDTH-1:0] rdata,
   input wire logic [WIDTH-1:0] periph_en,
   input wire logic [WIDTH-1:0] periph_out,
   input wire logic [WIDTH-1:0] periph_oe,
   output logic [WIDTH-1:0] periph_in,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_out,
   output logic [WIDTH-1:0] pin_oe
);

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   // Bits outside IMPL_MASK are never stored, so a read of a missing
   // bit can only return zero; the masks cost nothing once the tool
   // folds the constant
   logic [WIDTH-1:0] direction;  // One bit per pin, one means input
   logic [WIDTH-1:0] latch;  // Output latch
   logic [WIDTH-1:0] od_select;  // Open-drain select
   logic [WIDTH-1:0] analog_cfg;  // One marks an analog input channel
   logic [WIDTH-1:0] pin_sample;  // Pin levels in the clock domain

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   // One select per register, at most one high
   wire hit_dir = (addr == SPIOP_OFS_DIR);
   wire hit_pinval = (addr == SPIOP_OFS_PINVAL);
   wire hit_latch = (addr == SPIOP_OFS_LATCH);
   wire hit_odsel = (addr == SPIOP_OFS_ODSEL);
   wire hit_ancfg = (addr == SPIOP_OFS_ANCFG);
   // Any mapped register; a miss reads zero and drops writes
   wire hit_any = hit_dir | hit_pinval | hit_latch | hit_odsel | hit_ancfg;
   // Whole-byte compare, so no register shows up at an alias offset
   wire wr_dir = wr && hit_dir;
   // Writes to the pin value address land in the latch
   wire wr_latch = wr && (hit_latch || hit_pinval);
   wire wr_odsel = wr && hit_odsel;
   wire wr_ancfg = wr && hit_ancfg;
   // Missing bits never store anything
   wire [WIDTH-1:0] wmask = wdata & IMPL_MASK;
   // Writes replace whole words: there is no set, clear or toggle alias,
   // so software must read, modify and write to change a single pin

   // ------------------------------------------------------------
   // Direction register
   // ------------------------------------------------------------
   // reset forces inputs
   // Coming up as inputs keeps the pads from fighting the board
   // before software has chosen a direction
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         // Every implemented pin an input
         direction <= SPIOP_DIR_RST & IMPL_MASK;
      end else if (wr_dir) begin
         // Whole word replaced
         direction <= wmask;
      end
   end

   // ------------------------------------------------------------
   // Output latch
   // ------------------------------------------------------------
   // latch write path
   // pin value write redirected
   // The latch keeps its value while a peripheral owns the pin, so the
   // port level comes back unchanged when the peripheral lets go
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         latch <= SPIOP_LATCH_RST;
      end else if (wr_latch) begin
         latch <= wmask;
      end
   end

   // ------------------------------------------------------------
   // Open-drain and analog configuration
   // ------------------------------------------------------------
   // Both are plain storage, cleared at reset
   // Analog config only masks the digital read; the driver still follows
   // the direction bit, so an analog pin left as an output is converted
   // at its own driven level
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         od_select <= SPIOP_ODSEL_RST;
         analog_cfg <= SPIOP_ANCFG_RST;
      end else begin
         if (wr_odsel) begin
            od_select <= wmask;
         end
         if (wr_ancfg) begin
            analog_cfg <= wmask;
         end
      end
   end

   // ------------------------------------------------------------
   // Pin sampling
   // ------------------------------------------------------------
   // pins sampled each cycle
   // Inputs arrive synchronous, so one register stage is enough
   // Limitation: a truly asynchronous pad needs a second stage in front,
   // which adds a cycle to every read of the pin value
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pin_sample <= SPIOP_ZERO;
      end else begin
         pin_sample <= pin_in & IMPL_MASK;
      end
   end

   // ------------------------------------------------------------
   // Per-pin output multiplexers
   // ------------------------------------------------------------
   // A peripheral takes a pin only while enabled, actively driving and
   // wired to an output; otherwise the port bit keeps the pin. Open
   // drain applies to whichever source wins, so a peripheral on an
   // open-drain pin also only pulls low.
   logic [WIDTH-1:0] owns;  // Peripheral holds the output
   logic [WIDTH-1:0] port_drive;  // Port itself drives the pin
   logic [WIDTH-1:0] next_pin_out;
   logic [WIDTH-1:0] next_pin_oe;
   logic [WIDTH-1:0] next_periph_in;

   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_pin
         wire mux_data;  // Selected output level
         wire mux_en;  // Selected driver enable
         // input-only peripherals never own a pin
         assign owns[gi] = PERIPH_OUT_MASK[gi] & periph_en[gi] & periph_oe[gi];
         assign port_drive[gi] = ~owns[gi] & ~direction[gi];
         assign mux_data = owns[gi] ? periph_out[gi] : latch[gi];
         assign mux_en = owns[gi] | port_drive[gi];
         assign next_pin_oe[gi] = IMPL_MASK[gi] & mux_en & (~od_select[gi] | ~mux_data);
         assign next_pin_out[gi] = IMPL_MASK[gi] & mux_data & ~od_select[gi];
         assign next_periph_in[gi] = pin_sample[gi] & ~port_drive[gi];
      end
   endgenerate

   // ------------------------------------------------------------
   // Registered pin side outputs
   // ------------------------------------------------------------
   // Registered so the pads see glitch-free levels
   // Trade-off: a latch or direction write reaches the pad one cycle
   // after it lands in its register
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pin_out <= SPIOP_ZERO;
         pin_oe <= SPIOP_ZERO;
         periph_in <= SPIOP_ZERO;
      end else begin
         pin_out <= next_pin_out;
         pin_oe <= next_pin_oe;
         periph_in <= next_periph_in;
      end
   end

   // ------------------------------------------------------------
   // Read multiplexer
   // ------------------------------------------------------------
   // Pin value view: pins as sampled, analog channels and missing bits
   // forced low
   // analog channels read low
   wire [WIDTH-1:0] pinval_view = pin_sample & ~analog_cfg & IMPL_MASK;
   wire [WIDTH-1:0] rd_sel =
      hit_dir ? (direction & IMPL_MASK) :
      hit_pinval ? pinval_view :
      hit_latch ? (latch & IMPL_MASK) :
      hit_odsel ? (od_select & IMPL_MASK) :
      hit_ancfg ? (analog_cfg & IMPL_MASK) :
      SPIOP_ZERO;
   // Unmapped reads return zero
   // Idle cycles also return zero, so a stale word never lingers on the
   // shared read bus
   wire [WIDTH-1:0] next_rdata = rd ? rd_sel : SPIOP_ZERO;

   // readback valid in the cycle right after the strobe
   // Read data stand only in the cycle after the strobe
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rdata <= SPIOP_ZERO;
      end else begin
         rdata <= next_rdata;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);
   // All checks run on the one clock and sleep while reset is held; the
   // register checks compare against the state one edge earlier

   // Bus request shapes
   sequence wr_latch_seq;
      wr && (addr == SPIOP_OFS_LATCH);
   endsequence
   sequence wr_pinval_seq;
      wr && (addr == SPIOP_OFS_PINVAL);
   endsequence
   sequence rd_latch_seq;
      rd && (addr == SPIOP_OFS_LATCH);
   endsequence
   sequence rd_pinval_seq;
      rd && (addr == SPIOP_OFS_PINVAL);
   endsequence
   sequence wr_dir_seq;
      wr && (addr == SPIOP_OFS_DIR);
   endsequence
   sequence rd_dir_seq;
      rd && (addr == SPIOP_OFS_DIR);
   endsequence
   sequence wr_odsel_seq;
      wr && (addr == SPIOP_OFS_ODSEL);
   endsequence
   sequence rd_odsel_seq;
      rd && (addr == SPIOP_OFS_ODSEL);
   endsequence
   sequence wr_ancfg_seq;
      wr && (addr == SPIOP_OFS_ANCFG);
   endsequence
   sequence rd_ancfg_seq;
      rd && (addr == SPIOP_OFS_ANCFG);
   endsequence
   // Read strobe to no mapped register
   sequence rd_unmapped_seq;
      rd && !hit_any;
   endsequence
   // Read of the pins with a full sample cycle since reset
   sequence rd_settled_seq;
      rd_pinval_seq ##0 $past(rstn);
   endsequence

   dir_reset_a: assert property ($rose(rstn) |-> direction == (SPIOP_DIR_RST & IMPL_MASK))
      else $error("direction not all inputs after reset");

   latch_write_a: assert property (wr_latch_seq |=> latch == $past(wmask))
      else $error("latch write not stored");

   latch_read_a: assert property (rd_latch_seq |=> rdata == $past(latch & IMPL_MASK))
      else $error("latch read mismatch");

   pinval_write_a: assert property (wr_pinval_seq |=> latch == $past(wmask))
      else $error("pin value write missed latch");

   pinval_read_a: assert property (rd_pinval_seq |=> rdata == $past(pinval_view))
      else $error("pin value read mismatch");

   analog_zero_a: assert property (rd_pinval_seq |=> (rdata & $past(analog_cfg)) == SPIOP_ZERO)
      else $error("analog pin read nonzero");

   unimpl_zero_a: assert property (((rdata | pin_oe) & ~IMPL_MASK) == SPIOP_ZERO)
      else $error("unimplemented bit active");

   od_no_high_a: assert property (1'b1 |=> (pin_out & $past(od_select)) == SPIOP_ZERO)
      else $error("open-drain pin driven high");

   input_no_drive_a: assert property (1'b1 |=> (pin_oe & $past(direction & ~owns)) == SPIOP_ZERO)
      else $error("input pin driven by port");

   periph_mux_a: assert property (1'b1 |=>
      ((pin_oe ^ $past(owns)) & $past(owns & ~od_select) & IMPL_MASK) == SPIOP_ZERO)
      else $error("owned pin enable not from peripheral");

   periph_data_a: assert property (1'b1 |=>
      ((pin_out ^ $past(periph_out)) & $past(owns & ~od_select) & IMPL_MASK) == SPIOP_ZERO)
      else $error("owned pin data not from peripheral");

   no_loop_a: assert property (1'b1 |=> (periph_in & $past(port_drive)) == SPIOP_ZERO)
      else $error("port output looped into peripheral");

   dedicated_a: assert property (1'b1 |=>
      ((pin_oe ^ $past(~direction)) & ~PERIPH_OUT_MASK & ~$past(od_select)
       & IMPL_MASK) == SPIOP_ZERO)
      else $error("dedicated pin not port driven");

   dir_write_a: assert property (wr_dir_seq |=> direction == $past(wmask))
      else $error("direction write not stored");

   dir_read_a: assert property (rd_dir_seq |=> rdata == $past(direction))
      else $error("direction read mismatch");

   odsel_write_a: assert property (wr_odsel_seq |=> od_select == $past(wmask))
      else $error("open-drain select write not stored");

   odsel_read_a: assert property (rd_odsel_seq |=> rdata == $past(od_select))
      else $error("open-drain select read mismatch");

   ancfg_write_a: assert property (wr_ancfg_seq |=> analog_cfg == $past(wmask))
      else $error("analog config write not stored");

   ancfg_read_a: assert property (rd_ancfg_seq |=> rdata == $past(analog_cfg))
      else $error("analog config read mismatch");

   unmapped_read_a: assert property (rd_unmapped_seq |=> rdata == SPIOP_ZERO)
      else $error("unmapped read nonzero");

   rdata_idle_a: assert property (!rd |=> rdata == SPIOP_ZERO)
      else $error("read data outside read cycle");

   // Pins reach the read data two edges after they stand at the pad
   pin_latency_a: assert property (rd_settled_seq |=>
      rdata == ($past(pin_in, 2) & ~$past(analog_cfg) & IMPL_MASK))
      else $error("pin value read latency wrong");

   // Port-driven open-drain pin: enabled exactly when the latch is low
   od_release_a: assert property (1'b1 |=>
      ((pin_oe ^ ~$past(latch)) & $past(port_drive & od_select) & IMPL_MASK)
      == SPIOP_ZERO)
      else $error("open-drain pin not released");

endmodule

// file: rtl/spiop_pkg.sv
package spiop_pkg;

   // ------------------------------------------------------------
   // Port geometry
   // ------------------------------------------------------------
   localparam int SPIOP_WIDTH = 16;
   localparam int SPIOP_AW = 8;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [SPIOP_AW-1:0] SPIOP_OFS_DIR = 8'h00;
   localparam logic [SPIOP_AW-1:0] SPIOP_OFS_PINVAL = 8'h04;
   localparam logic [SPIOP_AW-1:0] SPIOP_OFS_LATCH = 8'h08;
   localparam logic [SPIOP_AW-1:0] SPIOP_OFS_ODSEL = 8'h0c;
   localparam logic [SPIOP_AW-1:0] SPIOP_OFS_ANCFG = 8'h10;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   // All pins come up as inputs
   localparam logic [SPIOP_WIDTH-1:0] SPIOP_DIR_RST = 16'hffff;
   localparam logic [SPIOP_WIDTH-1:0] SPIOP_LATCH_RST = 16'h0000;
   localparam logic [SPIOP_WIDTH-1:0] SPIOP_ODSEL_RST = 16'h0000;
   localparam logic [SPIOP_WIDTH-1:0] SPIOP_ANCFG_RST = 16'h0000;
   localparam logic [SPIOP_WIDTH-1:0] SPIOP_ZERO = 16'h0000;

   // ------------------------------------------------------------
   // Default pin population
   // ------------------------------------------------------------
   // Bits present on the package
   localparam logic [SPIOP_WIDTH-1:0] SPIOP_IMPL_DEF = 16'hffff;
   // Bits whose shared peripheral can drive the pin
   localparam logic [SPIOP_WIDTH-1:0] SPIOP_PERIPH_OUT_DEF = 16'hffff;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   // Cycles from a read strobe to its read data
   localparam int SPIOP_RD_LAT = 1;

endpackage

// file: tb/spiop_pins.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Board-side pin model
// ------------------------------------------------------------
module spiop_pins
   import spiop_pkg::*;
(
   input wire logic [SPIOP_WIDTH-1:0] pin_out,
   input wire logic [SPIOP_WIDTH-1:0] pin_oe,
   input wire logic [SPIOP_WIDTH-1:0] ext_val,
   input wire logic [SPIOP_WIDTH-1:0] ext_oe,
   output logic [SPIOP_WIDTH-1:0] pin_in
);
   // Port driver wins, then the external source, else the pull-up
   // released pin floats high
   // A released open-drain pin must read high, never the last driven 0
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val) | (~pin_oe & ~ext_oe);
endmodule

// file: tb/shared_parallel_io_port_tb.sv
`timescale 1ns/1ps
module shared_parallel_io_port_tb;
   import spiop_pkg::*;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   localparam logic [SPIOP_WIDTH-1:0] IMPL = 16'h7fff; // Bit 15 absent
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic [SPIOP_AW-1:0] addr = 8'h00;
   logic [SPIOP_WIDTH-1:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [SPIOP_WIDTH-1:0] periph_en = 16'h0000;
   logic [SPIOP_WIDTH-1:0] periph_out = 16'h0000;
   logic [SPIOP_WIDTH-1:0] periph_oe = 16'h0000;
   // External source keeps off bits 0-7 and 11, which the port or peripheral drive
   logic [SPIOP_WIDTH-1:0] ext_val = 16'h1300;
   logic [SPIOP_WIDTH-1:0] ext_oe = 16'hf700;
   logic [SPIOP_WIDTH-1:0] rdata, periph_in, pin_in, pin_out, pin_oe;
   int err_count = 0;
   int check_count = 0;
   always #4 clock = ~clock;
   // ------------------------------------------------------------
   // Instances
   // ------------------------------------------------------------
   // Bit 0 has an input-only companion, so the peripheral never drives it
   spiop_port #(.IMPL_MASK(IMPL), .PERIPH_OUT_MASK(16'hfffe)) spiop_port_i (
      .clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .periph_en(periph_en), .periph_out(periph_out),
      .periph_oe(periph_oe), .periph_in(periph_in), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe));
   spiop_pins spiop_pins_i (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
      .ext_oe(ext_oe), .pin_in(pin_in));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string nm);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      @(negedge clock);
      chk(nm, exp, rdata);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Guard against a hang
   initial begin
      #200us;
      err_count++;
      $display("mismatch run_timeout expected done seen hang");
      summarize();
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clock);
      rstn <= 1'b1;
      @(negedge clock);
      chk("pin_oe reset", 16'h0000, pin_oe);
      rd_chk(SPIOP_OFS_DIR, IMPL, "dir reset");
      rd_chk(SPIOP_OFS_LATCH, 16'h0000, "latch reset");
      $display("test reset done");
      wr_reg(SPIOP_OFS_DIR, 16'hff00);
      wr_reg(SPIOP_OFS_PINVAL, 16'ha5a5);
      repeat (3) @(posedge clock);
      rd_chk(SPIOP_OFS_LATCH, 16'h25a5, "latch");
      chk("pin_oe dir", 16'h00ff, pin_oe);
      chk("pin_out", 16'h25a5, pin_out);
      rd_chk(SPIOP_OFS_PINVAL, 16'h1ba5, "pins");
      rd_chk(SPIOP_OFS_DIR, 16'h7f00, "dir");
      $display("test direction done");
      wr_reg(SPIOP_OFS_ANCFG, 16'h0300);
      rd_chk(SPIOP_OFS_PINVAL, 16'h18a5, "pins analog");
      rd_chk(SPIOP_OFS_ANCFG, 16'h0300, "ancfg");
      wr_reg(SPIOP_OFS_ODSEL, 16'h000f);
      repeat (3) @(posedge clock);
      @(negedge clock);
      chk("pin_oe od", 16'h00fa, pin_oe);
      chk("pin_out od", 16'h25a0, pin_out);
      rd_chk(SPIOP_OFS_PINVAL, 16'h18a5, "pins od");
      rd_chk(SPIOP_OFS_ODSEL, 16'h000f, "odsel");
      wr_reg(SPIOP_OFS_ODSEL, 16'h0000);
      $display("test open drain done");
      @(posedge clock);
      periph_en <= 16'h0803;
      periph_oe <= 16'h0803;
      periph_out <= 16'h0802;
      repeat (4) @(posedge clock);
      @(negedge clock);
      chk("pin_oe periph", 16'h08ff, pin_oe);
      chk("pin_out periph", 16'h2da7, pin_out);
      chk("periph_in", 16'h1b02, periph_in & IMPL);
      rd_chk(SPIOP_OFS_PINVAL, 16'h18a7, "pins periph");
      rd_chk(8'h14, 16'h0000, "unmapped");
      wr_reg(SPIOP_OFS_LATCH, 16'hffff);
      rd_chk(SPIOP_OFS_LATCH, 16'h7fff, "latch direct");
      chk("pin_out latch", 16'h7fff, pin_out);
      $display("test peripheral done");
      @(posedge clock);
      rstn <= 1'b0;
      @(negedge clock);
      chk("pin_oe mid reset", 16'h0000, pin_oe);
      @(posedge clock);
      rstn <= 1'b1;
      rd_chk(SPIOP_OFS_DIR, IMPL, "dir after reset");
      $display("test second reset done");
      summarize();
   end
endmodule
